// file: ifd_pkg.sv
// Constants and types for the instruction field decoder.
// Assumes one 50 MHz core clock and 16-bit instruction words.
package ifd_pkg;
  // ************************************************************
  // Timing
  // ************************************************************
  localparam int CLK_NS = 20;
  localparam int OSC_PER_CYC = 4;
  localparam int TCY_NS = OSC_PER_CYC * CLK_NS;
  localparam logic [1:0] PHASE_LAST = 2'(OSC_PER_CYC - 1);
  // ************************************************************
  // Format selection and field positions
  // ************************************************************
  localparam logic [1:0] SEL_BYTE = 2'h0;
  localparam logic [1:0] SEL_CTL = 2'h3;
  localparam logic [2:0] SEL_PTOF = 3'h2;
  localparam logic [2:0] SEL_FTOP = 3'h3;
  localparam logic [2:0] SEL_BIT = 3'h4;
  localparam logic [3:0] SEL_TBL = 4'hA;
  localparam logic [3:0] SEL_LIT = 4'hB;
  localparam int F_HI = 7;
  localparam int P_LO = 8;
  localparam int P_HI = 12;
  localparam int B_LO = 8;
  localparam int B_HI = 10;
  localparam int K8_HI = 7;
  localparam int K13_HI = 12;
  localparam int D_BIT = 8;
  localparam int I_BIT = 8;
  localparam int T_BIT = 9;
  localparam int BOP_LO = 9;
  localparam int BOP_HI = 13;
  localparam int BTOP_LO = 11;
  localparam int BTOP_HI = 12;
  localparam int TOP_LO = 10;
  localparam int TOP_HI = 11;
  localparam int LOP_LO = 8;
  localparam int LOP_HI = 11;
  localparam int CTL_OP_BIT = 13;
  // ************************************************************
  // Operation numbering
  // ************************************************************
  localparam logic [5:0] OP_TOTAL = 6'h3A;
  localparam logic [5:0] ID_BIT = 6'h20;
  localparam logic [5:0] ID_MOVE = 6'h24;
  localparam logic [5:0] ID_TBL = 6'h26;
  localparam logic [5:0] ID_LIT = 6'h2A;
  localparam logic [5:0] ID_CTL = 6'h38;
  localparam logic [3:0] LIT_OPS = 4'hE;
  localparam logic [4:0] BOP_S_FIRST = 5'h10;
  localparam logic [4:0] BOP_SKIP_FIRST = 5'h18;
  localparam logic [1:0] BIT_TEST_FIRST = 2'h2;
  localparam logic [1:0] TB_LRD = 2'h0;
  localparam logic [1:0] TB_LWT = 2'h1;
  localparam logic [1:0] TB_RD = 2'h2;
  localparam logic [1:0] TB_WT = 2'h3;
  localparam logic DEST_DEFAULT = 1'h1;
  // ************************************************************
  // Register map
  // ************************************************************
  localparam logic [2:0] A_CSTAT = 3'h0;
  localparam logic [2:0] A_TPL = 3'h1;
  localparam logic [2:0] A_TPH = 3'h2;
  localparam logic [2:0] A_TLL = 3'h3;
  localparam logic [2:0] A_TLH = 3'h4;
  localparam logic [2:0] A_DSTAT = 3'h5;
  localparam int CSTAT_GID_BIT = 4;
  localparam logic [7:0] CSTAT_RST = 8'h10;
  localparam logic [7:0] CSTAT_WMASK = 8'h10;
  localparam logic [15:0] TPTR_RST = 16'h0000;
  localparam logic [15:0] TLAT_RST = 16'h0000;
  // ************************************************************
  // Types
  // ************************************************************
  typedef enum logic [2:0] {
    FMT_BYTE = 3'h0,
    FMT_BIT = 3'h1,
    FMT_MOVE = 3'h2,
    FMT_TBL = 3'h3,
    FMT_LIT = 3'h4,
    FMT_CTL = 3'h5
  } ifd_fmt_t;
  typedef enum logic [2:0] {
    ST_READY = 3'h1,
    ST_EXEC = 3'h2,
    ST_SECOND = 3'h4
  } ifd_state_t;
endpackage

// file: ifd_phase_if.sv
// Phase bundle between the clock quarterer and the decoder.
// Assumes both ends run on the same core clock.
interface ifd_phase_if;
  logic [1:0] phase;
  logic cyc_en;
  modport src (output phase, output cyc_en);
  modport dst (input phase, input cyc_en);
endinterface

// file: ifd_clk_quarter.sv
// Instruction cycle divider: four core clocks per instruction cycle.
// Assumes a free running core clock and asynchronous reset.
module ifd_clk_quarter
  import ifd_pkg::*;
(
  input wire logic clk, // Core clock
  input wire logic rst, // Async reset, high
  ifd_phase_if.src ph   // Phase and cycle enable
);
  logic [1:0] phase_reg;
  logic [1:0] phase_next;

  assign phase_next = (phase_reg == PHASE_LAST) ? 2'h0 : phase_reg + 2'h1;
  assign ph.phase = phase_reg;
  assign ph.cyc_en = (phase_reg == PHASE_LAST);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      phase_reg <= 2'h0;
    end else begin
      phase_reg <= phase_next;
    end
  end
endmodule

// file: ifd_decoder.sv
// Instruction field decoder with cycle sequencing and table transfer state.
// Assumes program memory answers table reads combinationally, and a
// datapath that supplies the addressed file byte and the test result.
//
// Our own choices: the register addresses and the plain strobed port.
module ifd_decoder
  import ifd_pkg::*;
(
  input wire logic clk,              // Core clock
  input wire logic rst,              // Async reset, high
  input wire logic [15:0] instr_word, // Instruction word
  input wire logic instr_valid,      // Word present
  output logic instr_take,           // Word taken this edge
  input wire logic cond_true,        // Test result of current op
  input wire logic [7:0] file_rdata, // Addressed file byte
  input wire logic [15:0] prog_rdata, // Program word at pointer
  output logic [5:0] op_id,          // Operation number
  output logic [2:0] fmt,            // Instruction format
  output logic illegal_op,           // Undefined encoding
  output logic [7:0] file_addr,      // File address
  output logic [4:0] periph_addr,    // Peripheral address
  output logic [2:0] bit_pos,        // Bit number
  output logic [7:0] bit_mask,       // One-hot bit
  output logic [12:0] literal,       // Literal value
  output logic lit_wide,             // Literal is 13 bits
  output logic dest_sel,             // Destination bit
  output logic tbl_half,             // Table byte select
  output logic tbl_step,             // Pointer autostep
  output logic wr_acc,               // Accumulator write
  output logic wr_file,              // File write
  output logic wr_periph,            // Peripheral write
  output logic pc_load,              // Program counter load
  output logic [7:0] file_wdata,     // Table byte to file
  output logic prog_rd,              // Table program read
  output logic prog_wr,              // Table program write
  output logic [15:0] prog_addr,     // Table pointer
  output logic [15:0] prog_wdata,    // Table latch
  output logic exec_cycle,           // First cycle of op
  output logic nop_cycle,            // Second, idle cycle
  output logic [1:0] instr_phase,    // Clock within cycle
  output logic [1:0] cycles_used,    // Cycles of last op
  output logic global_irq_disable,   // Interrupts held off
  input wire logic [2:0] reg_addr,   // Register address
  input wire logic [7:0] reg_wdata,  // Register write data
  input wire logic reg_wr,           // Register write
  input wire logic reg_rd,           // Register read
  output logic [7:0] reg_rdata       // Read data, next cycle
);
  // ************************************************************
  // Instruction cycle timing
  // ************************************************************
  ifd_phase_if ph ();

  ifd_clk_quarter u_quarter (
    .clk(clk),
    .rst(rst),
    .ph(ph.src)
  );

  wire cyc_en = ph.cyc_en;
  assign instr_phase = ph.phase;

  // ************************************************************
  // Format selection and field extraction
  // ************************************************************
  wire [1:0] top2 = instr_word[15:14];
  wire [2:0] top3 = instr_word[15:13];
  wire [3:0] top4 = instr_word[15:12];
  wire is_byte_w = (top2 == SEL_BYTE);
  wire is_ctl_w = (top2 == SEL_CTL);
  wire is_ftop_w = (top3 == SEL_FTOP);
  wire is_move_w = (top3 == SEL_PTOF) || is_ftop_w;
  wire is_bit_w = (top3 == SEL_BIT);
  wire is_tbl_w = (top4 == SEL_TBL);
  wire is_lit_w = (top4 == SEL_LIT);
  wire [4:0] bop_w = instr_word[BOP_HI:BOP_LO];
  wire [1:0] btop_w = instr_word[BTOP_HI:BTOP_LO];
  wire [1:0] tbop_w = instr_word[TOP_HI:TOP_LO];
  wire [3:0] lop_w = instr_word[LOP_HI:LOP_LO];
  wire [2:0] bnum_w = instr_word[B_HI:B_LO];

  ifd_fmt_t fmt_w;
  assign fmt_w = is_byte_w ? FMT_BYTE :
                 is_ctl_w ? FMT_CTL :
                 is_move_w ? FMT_MOVE :
                 is_bit_w ? FMT_BIT :
                 is_tbl_w ? FMT_TBL : FMT_LIT;

  logic [5:0] op_id_w;
  assign op_id_w = is_byte_w ? {1'h0, bop_w} :
                   is_ctl_w ? ID_CTL + {5'h00, instr_word[CTL_OP_BIT]} :
                   is_move_w ? ID_MOVE + {5'h00, is_ftop_w} :
                   is_bit_w ? ID_BIT + {4'h0, btop_w} :
                   is_tbl_w ? ID_TBL + {4'h0, tbop_w} :
                   ID_LIT + {2'h0, lop_w};
  wire illegal_w = is_lit_w && (lop_w >= LIT_OPS);

  wire s_type_w = is_byte_w && (bop_w >= BOP_S_FIRST) && (bop_w < BOP_SKIP_FIRST);
  wire cond_w = (is_byte_w && (bop_w >= BOP_SKIP_FIRST)) ||
                (is_bit_w && (btop_w >= BIT_TEST_FIRST));
  wire dest_w = is_byte_w ? instr_word[D_BIT] : DEST_DEFAULT;
  wire [12:0] lit_w = is_ctl_w ? instr_word[K13_HI:0] :
                      {5'h00, instr_word[K8_HI:0]};

  // ************************************************************
  // Sequencing
  // ************************************************************
  ifd_state_t state_reg;
  ifd_state_t state_next;
  ifd_fmt_t fmt_reg;
  logic cond_reg;
  logic s_type_reg;
  logic dest_reg;
  logic [1:0] tbop_reg;
  logic [15:0] tptr_reg;
  logic [15:0] tptr_next;
  logic [15:0] tlat_reg;
  logic [15:0] tlat_next;
  logic [7:0] cstat_reg;
  logic [7:0] rdata_next;

  wire in_exec = (state_reg == ST_EXEC);
  wire in_second = (state_reg == ST_SECOND);
  wire commit = cyc_en && in_exec;
  wire is_tbl_r = (fmt_reg == FMT_TBL);
  wire need_extra = (fmt_reg == FMT_CTL) || is_tbl_r ||
                    (cond_reg && cond_true);
  wire can_take = (state_reg == ST_READY) || in_second ||
                  (in_exec && !need_extra);
  wire tbl_done = cyc_en && in_second && is_tbl_r;

  assign instr_take = cyc_en && instr_valid && can_take;
  assign exec_cycle = in_exec;
  assign nop_cycle = in_second;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_READY: begin
        if (instr_take) state_next = ST_EXEC;
      end
      ST_EXEC: begin
        if (cyc_en && need_extra) begin
          state_next = ST_SECOND;
        end else if (cyc_en && !instr_valid) begin
          state_next = ST_READY;
        end
      end
      ST_SECOND: begin
        if (cyc_en) state_next = instr_valid ? ST_EXEC : ST_READY;
      end
      default: state_next = ST_READY;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= ST_READY;
      cycles_used <= 2'h0;
    end else begin
      state_reg <= state_next;
      if (commit) cycles_used <= need_extra ? 2'h2 : 2'h1;
    end
  end

  // ************************************************************
  // Field registers, loaded when a word is taken
  // ************************************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fmt_reg <= FMT_BYTE;
      op_id <= 6'h00;
      illegal_op <= 1'h0;
      cond_reg <= 1'h0;
      s_type_reg <= 1'h0;
      dest_reg <= DEST_DEFAULT;
      tbop_reg <= TB_LRD;
    end else if (instr_take) begin
      fmt_reg <= fmt_w;
      op_id <= op_id_w;
      illegal_op <= illegal_w;
      cond_reg <= cond_w;
      s_type_reg <= s_type_w;
      dest_reg <= dest_w;
      tbop_reg <= tbop_w;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      file_addr <= 8'h00;
      periph_addr <= 5'h00;
      bit_pos <= 3'h0;
      bit_mask <= 8'h01;
      literal <= 13'h0000;
      lit_wide <= 1'h0;
      tbl_half <= 1'h0;
      tbl_step <= 1'h0;
    end else if (instr_take) begin
      file_addr <= instr_word[F_HI:0];
      periph_addr <= instr_word[P_HI:P_LO];
      bit_pos <= bnum_w;
      bit_mask <= 8'h01 << bnum_w;
      literal <= lit_w;
      lit_wide <= is_ctl_w;
      tbl_half <= instr_word[T_BIT];
      tbl_step <= instr_word[I_BIT];
    end
  end

  assign fmt = fmt_reg;
  assign dest_sel = dest_reg;

  // ************************************************************
  // Result routing, pulsed at the end of the execute cycle, prog_wr at the end of the second cycle
  // ************************************************************
  wire tb_rd_op = is_tbl_r && (tbop_reg == TB_RD);
  wire tb_wt_op = is_tbl_r && (tbop_reg == TB_WT);
  wire tb_to_file = is_tbl_r && ((tbop_reg == TB_LRD) || tb_rd_op);
  wire tb_from_file = is_tbl_r && ((tbop_reg == TB_LWT) || tb_wt_op);
  wire byte_wr = (fmt_reg == FMT_BYTE) && !cond_reg;
  wire acc_w = (byte_wr && !dest_reg) ||
               ((fmt_reg == FMT_LIT) && !illegal_op);
  wire file_w = (byte_wr && (dest_reg || s_type_reg)) ||
                ((fmt_reg == FMT_BIT) && !cond_reg) ||
                ((fmt_reg == FMT_MOVE) && !op_id[0]) ||
                tb_to_file;
  wire [7:0] tl_byte = tbl_half ? tlat_reg[15:8] : tlat_reg[7:0];

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_acc <= 1'h0;
      wr_file <= 1'h0;
      wr_periph <= 1'h0;
      pc_load <= 1'h0;
      prog_rd <= 1'h0;
      prog_wr <= 1'h0;
    end else begin
      wr_acc <= commit && acc_w;
      wr_file <= commit && file_w;
      wr_periph <= commit && (fmt_reg == FMT_MOVE) && op_id[0];
      pc_load <= commit && (fmt_reg == FMT_CTL);
      prog_rd <= commit && tb_rd_op;
      prog_wr <= tbl_done && tb_wt_op;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      file_wdata <= 8'h00;
    end else if (commit && tb_to_file) begin
      file_wdata <= tl_byte;
    end
  end

  // ************************************************************
  // Register port
  // ************************************************************
  wire cs_wr = reg_wr && (reg_addr == A_CSTAT);
  wire tpl_wr = reg_wr && (reg_addr == A_TPL);
  wire tph_wr = reg_wr && (reg_addr == A_TPH);
  wire tll_wr = reg_wr && (reg_addr == A_TLL);
  wire tlh_wr = reg_wr && (reg_addr == A_TLH);
  wire tp_sw = tpl_wr || tph_wr;
  wire tl_sw = tll_wr || tlh_wr;

  assign tptr_next = tpl_wr ? {tptr_reg[15:8], reg_wdata} :
                     tph_wr ? {reg_wdata, tptr_reg[7:0]} :
                     (tbl_done && tbl_step) ? tptr_reg + 16'h0001 :
                     tptr_reg;

  assign tlat_next = tll_wr ? {tlat_reg[15:8], reg_wdata} :
                     tlh_wr ? {reg_wdata, tlat_reg[7:0]} :
                     (commit && tb_rd_op) ? prog_rdata :
                     (commit && tb_from_file && tbl_half) ?
                       {file_rdata, tlat_reg[7:0]} :
                     (commit && tb_from_file) ?
                       {tlat_reg[15:8], file_rdata} :
                     tlat_reg;

  assign rdata_next = (reg_addr == A_CSTAT) ? cstat_reg :
                      (reg_addr == A_TPL) ? tptr_reg[7:0] :
                      (reg_addr == A_TPH) ? tptr_reg[15:8] :
                      (reg_addr == A_TLL) ? tlat_reg[7:0] :
                      (reg_addr == A_TLH) ? tlat_reg[15:8] :
                      (reg_addr == A_DSTAT) ? {state_reg, fmt_reg, cycles_used} :
                      8'h00;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tptr_reg <= TPTR_RST;
      tlat_reg <= TLAT_RST;
    end else begin
      tptr_reg <= tptr_next;
      tlat_reg <= tlat_next;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cstat_reg <= CSTAT_RST;
      reg_rdata <= 8'h00;
    end else begin
      if (cs_wr) cstat_reg <= reg_wdata & CSTAT_WMASK;
      reg_rdata <= reg_rd ? rdata_next : 8'h00;
    end
  end

  assign global_irq_disable = cstat_reg[CSTAT_GID_BIT];
  assign prog_addr = tptr_reg;
  assign prog_wdata = tlat_reg;

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence cyc_gap_s;
    !cyc_en [*3] ##1 cyc_en;
  endsequence

  sequence nop_run_s;
    nop_cycle [*4];
  endsequence

  cyc_period_a: assert property (cyc_en |=> cyc_gap_s)
    else $error("cycle enable not every fourth clock");

  take_edge_a: assert property (instr_take |-> cyc_en && !(in_exec && need_extra))
    else $error("word taken off a cycle boundary");

  byte_dest_a: assert property (commit && fmt_reg == FMT_BYTE && !s_type_reg &&
      !cond_reg |=> wr_file == $past(dest_reg) && wr_acc == !$past(dest_reg))
    else $error("byte result routed to wrong place");

  dual_write_a: assert property (commit && s_type_reg |=>
      wr_file && (wr_acc != $past(dest_reg)))
    else $error("dual write select not honoured");

  table_nop_a: assert property (commit && is_tbl_r |=> nop_run_s ##1 !nop_cycle)
    else $error("table op not two cycles");

  single_cycle_a: assert property (commit && !need_extra |=> !nop_cycle [*4])
    else $error("plain op took an extra cycle");

  extra_cycle_a: assert property (commit && cond_reg && cond_true |=>
      nop_run_s)
    else $error("true test did not add a cycle");

  ptr_step_a: assert property (tbl_done && tbl_step && !tp_sw |=>
      tptr_reg == $past(tptr_reg) + 16'h0001)
    else $error("table pointer did not step");

  ptr_hold_a: assert property (tbl_done && !tbl_step && !tp_sw |=>
      $stable(tptr_reg))
    else $error("table pointer moved without autostep");

  half_select_a: assert property (commit && tb_from_file && tbl_half && !tl_sw |=>
      tlat_reg[15:8] == $past(file_rdata) &&
      tlat_reg[7:0] == $past(tlat_reg[7:0]))
    else $error("high latch byte write went astray");

  periph_field_a: assert property (instr_take |=>
      periph_addr == $past(instr_word[P_HI:P_LO]))
    else $error("peripheral field misplaced");

  file_field_a: assert property (instr_take |=>
      file_addr == $past(instr_word[F_HI:0]))
    else $error("file field misplaced");

  gid_read_a: assert property (reg_rd && reg_addr == A_CSTAT |=>
      reg_rdata[CSTAT_GID_BIT] == global_irq_disable)
    else $error("interrupt disable bit misplaced");
endmodule

// file: ifd_prog_mem.sv
// Program memory model offering instruction words and table data.
// Assumes the decoder takes a word at an edge where instr_take is high.
module ifd_prog_mem (
  input wire logic clk, // Core clock
  input wire logic rst, // Async reset, high
  input wire logic [15:0] next_word, // Word to offer
  input wire logic next_load, // Offer next_word
  input wire logic instr_take, // Word taken
  input wire logic [15:0] prog_addr, // Table pointer
  output logic [15:0] instr_word, // Offered word
  output logic instr_valid, // Word present
  output logic [15:0] prog_rdata // Word at pointer
);
  // ************************************************************
  // Fetch
  // ************************************************************
  // A taken word is inverted so stale data never passes for valid
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      instr_valid <= 1'b0;
      instr_word <= 16'h0000;
    end else if (next_load) begin
      instr_valid <= 1'b1;
      instr_word <= next_word;
    end else if (instr_take) begin
      instr_valid <= 1'b0;
      instr_word <= ~instr_word;
    end
  end
  assign prog_rdata = prog_addr ^ 16'hA5C3;
endmodule

// file: tb.sv
// Self-checking bench for the instruction field decoder.
// Assumes ifd_pkg, the decoder and the memory model are compiled first.
module tb
  import ifd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, ld, instr_take, instr_valid, cond_true, reg_wr, reg_rd, illegal_op;
  logic lit_wide, dest_sel, tbl_half, tbl_step, wr_acc, wr_file, wr_periph, pc_load;
  logic prog_rd, prog_wr, exec_cycle, nop_cycle, global_irq_disable;
  logic [15:0] nxt, instr_word, prog_rdata, prog_addr, prog_wdata;
  logic [12:0] literal;
  logic [7:0] file_rdata, file_addr, bit_mask, file_wdata, reg_wdata, reg_rdata, fw, fr, rv;
  logic [5:0] op_id;
  logic [4:0] periph_addr;
  logic [2:0] fmt, bit_pos, reg_addr;
  logic [1:0] instr_phase, cycles_used;
  logic [15:0] cw [9] = '{16'h0000, 16'h0100, 16'h2000, 16'h3000, 16'h9000, 16'hA800,
    16'hAC00, 16'hC000, 16'hBE00};
  int n_errors, checks, seed, cyc;
  ifd_decoder DUT (.*);
  ifd_prog_mem mem (.clk, .rst, .next_word(nxt), .next_load(ld), .instr_take,
    .prog_addr, .instr_word, .instr_valid, .prog_rdata);
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      results();
    end
  end
  // ************************************************************
  // Checks and expectations
  // ************************************************************
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task results;
    if (n_errors == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Pulses: two-cycle, acc, file, periph, pc, prog read, prog write
  function automatic logic [6:0] ex(input logic [15:0] w, input logic c);
    casez (w[15:12])
      4'b00??: return w[13] ? (w[12] ? {c, 6'h00} : {1'b0, !w[8], 5'h10}) : {1'b0, !w[8], w[8], 4'h0};
      4'b010?: return 7'h10;
      4'b011?: return 7'h08;
      4'b100?: return w[12] ? {c, 6'h00} : 7'h10;
      4'b1010: return {2'b10, !w[10], 2'b00, w[11] & !w[10], w[11] & w[10]};
      4'b11??: return 7'h44;
      default: return 7'h00;
    endcase
  endfunction
  function automatic logic [8:0] fo(input logic [15:0] w);
    casez (w[15:12])
      4'b00??: return {3'h0, 6'(w[13:9])};
      4'b01??: return {3'h2, ID_MOVE + 6'(w[13])};
      4'b100?: return {3'h1, ID_BIT + 6'(w[12:11])};
      4'b1010: return {3'h3, ID_TBL + 6'(w[11:10])};
      4'b1011: return {3'h4, ID_LIT + 6'(w[11:8])};
      default: return {3'h5, ID_CTL + 6'(w[13])};
    endcase
  endfunction
  task wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk) begin reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d; end
    @(posedge clk) reg_wr <= 1'b0;
  endtask
  task rd(input logic [2:0] a);
    @(posedge clk) begin reg_rd <= 1'b1; reg_addr <= a; end
    @(posedge clk) reg_rd <= 1'b0;
    #1 rv = reg_rdata;
  endtask
  task op(input logic [15:0] w);
    logic c, il;
    logic [6:0] p, e;
    logic [8:0] f;
    int k, ne, nn;
    c = 1'($random(seed));
    fr = 8'($random(seed));
    il = w[15:12] == 4'hB && w[11:9] == 3'h7;
    f = fo(w);
    e = ex(w, c);
    p = 7'h00; ne = 0; nn = 0; k = 0; fw = 8'h00;
    @(posedge clk) begin nxt <= w; ld <= 1'b1; cond_true <= c; file_rdata <= fr; end
    @(posedge clk) ld <= 1'b0;
    #1;
    while (instr_take !== 1'b1 && k < 20) begin @(posedge clk); #1; k++; end
    chk(instr_phase, PHASE_LAST);
    @(posedge clk) #1;
    chk({file_addr, periph_addr, bit_pos, bit_mask}, {w[7:0], w[12:8], w[10:8], 8'h01 << w[10:8]});
    chk({literal, lit_wide}, {w[15:14] == 2'b11 ? w[12:0] : {5'h00, w[7:0]}, w[15:14] == 2'b11});
    chk({dest_sel, tbl_half, tbl_step}, {w[15:14] != 2'b00 | w[8], w[9], w[8]});
    chk({fmt, illegal_op}, {f[8:6], il});
    if (!il) chk(op_id, f[5:0]);
    repeat (12) begin
      ne += int'(exec_cycle === 1'b1);
      nn += int'(nop_cycle === 1'b1);
      p |= {1'b0, wr_acc, wr_file, wr_periph, pc_load, prog_rd, prog_wr};
      if (wr_file === 1'b1) fw = file_wdata;
      @(posedge clk) #1;
    end
    chk(ne, 4);
    chk(nn, e[6] ? 4 : 0);
    chk(cycles_used, e[6] ? 2'd2 : 2'd1);
    if (w[15:12] != 4'hB) chk(p, {1'b0, e[5:0]});
  endtask
  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    rst = 1'b1; ld = 0; nxt = 0; cond_true = 0; file_rdata = 0;
    reg_wr = 0; reg_rd = 0; reg_addr = 0; reg_wdata = 0;
    seed = 60; n_errors = 0; checks = 0; cyc = 0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk({dest_sel, bit_mask, global_irq_disable, cycles_used}, {1'b1, 8'h01, 1'b1, 2'd0});
    rd(A_CSTAT);
    chk(rv, CSTAT_RST);
    wr(A_CSTAT, 8'hEF);
    rd(A_CSTAT);
    chk({rv, global_irq_disable}, 9'h000);
    rd(3'h6);
    chk(rv, 8'h00);
    wr(A_TPL, 8'hFF);
    wr(A_TPH, 8'h12);
    wr(A_TLL, 8'h5A);
    wr(A_TLH, 8'hC3);
    op(16'hA000);
    chk({fw, prog_addr}, 24'h5A12FF);
    op(16'hA300);
    chk({fw, prog_addr}, 24'hC31300);
    op(16'hA600);
    rd(A_TLH);
    chk({rv, prog_wdata[7:0]}, {fr, 8'h5A});
    rd(A_DSTAT);
    chk(rv, 8'h2E);
    foreach (cw[i]) op(cw[i]);
    repeat (150) op(16'($random(seed)));
    results();
  end
endmodule
